//--- sdip_port.sv
// serial input port of a 16-bit converter, sampled on ref_clk
// Notes on behaviour
// RQ1: while select is high the serial data pin is never looked at.
// RQ2: while select is high bit clock edges neither shift nor update the latch.
// RQ3: words are only taken while select stays low for the whole transfer.
// RQ4: clear low during the 16th bit clock loads midcode on that clock's falling edge.
// RQ5: clear high during the 16th bit clock loads the shift register on that falling edge.
// RQ6: each word is 16 bits twos complement, most significant bit first.
// RQ7: the host waits at least 100 ns after the 16th falling edge before selecting again.
// RQ8: the host keeps select high at least 20 ns between transfers.
// RQ9: the host waits at least 20 ns from select low to the first rising bit clock.
// RQ10: the host keeps select high at least 100 us after power up.
// RQ11: after select falls each rising bit clock shifts data into a 16-bit register.
// RQ12: after the latch update further bit clocks are ignored until select falls again.
// RQ13: select rising before the update discards the partial word and keeps the latch.
// RQ14: midcode is 0000, full positive scale 7FFF, full negative scale 8000.
// RQ15: at reset the latch holds midcode and the bit counter is cleared.
`timescale 1ns/100ps
`include "sdip_consts.svh"
module sdip_port #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // serial pins from the host
  input  wire sdip_pkg::sdip_pins_t pins,
  // converter latch
  output sdip_pkg::sdip_word_t     dac_latch,
  output logic                     latch_load,
  // stream of latched words
  output logic                     word_valid,
  input  wire logic                word_ready,
  output sdip_pkg::sdip_word_t     word_data,
  output logic                     word_dropped
);
  import sdip_pkg::*;

  // pin pipeline and edge history
  sdip_pins_t  pin_s1, pin_s2;
  sdip_pins_t  next_pin_s1, next_pin_s2;
  logic        clk_prev, sel_prev;
  logic        next_clk_prev, next_sel_prev;
  logic        rise, fall, sel_fall;

  // frame state, datapath and latch
  sdip_state_t state, next_state;
  logic [4:0]  bit_cnt, next_bit_cnt;
  sdip_word_t  shreg, next_shreg, next_latch;
  logic        next_load, clr_at16, next_clr_at16;
  logic        shift_now, cnt_clear, last_bit, load_mid;

  // buffer side
  logic        fifo_in_ready, next_dropped;

  // edge finder used for both bit clock edges and the select edge; the gate
  // term keeps a deselected port blind to every bit clock edge
  function automatic logic edge_seen(input logic now_lvl,
                                     input logic old_lvl,
                                     input logic want_high,
                                     input logic gate_open);
    edge_seen = gate_open && (now_lvl == want_high) && (old_lvl != want_high);
  endfunction

  // synchroniser stages: stage one takes the raw pins, only stage two is decoded;
  // each bit clock phase must last more than one ref_clk period to be seen
  always_comb begin
    next_pin_s1   = pins;
    next_pin_s2   = pin_s1;
    next_clk_prev = pin_s2.bit_clk;
    next_sel_prev = pin_s2.sel_n;
  end

  // two-stage synchroniser on every pin; only stage two is read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1   <= '{sel_n: 1'b1, bit_clk: 1'b0, data: 1'b0, force_midcode_n: 1'b1};
      pin_s2   <= '{sel_n: 1'b1, bit_clk: 1'b0, data: 1'b0, force_midcode_n: 1'b1};
      clk_prev <= 1'b0;
      sel_prev <= 1'b1;
    end else begin
      pin_s1   <= next_pin_s1;
      pin_s2   <= next_pin_s2;
      clk_prev <= next_clk_prev;
      sel_prev <= next_sel_prev;
    end
  end

  // edges are gated by select so a deselected port sees nothing;
  // a rise shifts a bit, a fall may load the latch, a select fall opens a frame
  assign rise     = edge_seen(pin_s2.bit_clk, clk_prev, 1'b1, !pin_s2.sel_n);  // [RQ2]
  assign fall     = edge_seen(pin_s2.bit_clk, clk_prev, 1'b0, !pin_s2.sel_n);  // [RQ2]
  assign sel_fall = edge_seen(pin_s2.sel_n, sel_prev, 1'b0, 1'b1);

  // frame sequencer: shift, wait for the 16th falling edge, then ignore clocks;
  // the load shows three ref_clk edges after the pin edge (two sync, one register)
  always_comb begin
    next_state    = state;
    next_clr_at16 = clr_at16;
    next_load     = 1'b0;
    shift_now     = 1'b0;
    cnt_clear     = 1'b0;
    last_bit      = (bit_cnt == 5'(`SDIP_WORD_BITS - 1));
    if (pin_s2.sel_n) begin
      // deselect drops any partial word, latch untouched
      next_state = SDIP_IDLE;                                       // [RQ13] [RQ1]
      cnt_clear  = 1'b1;
    end else begin
      unique case (state)
        SDIP_IDLE: begin
          if (sel_fall) begin
            next_state = SDIP_SHIFT;                                // [RQ3]
            cnt_clear  = 1'b1;
          end
        end
        SDIP_SHIFT: begin
          if (rise) begin
            shift_now = 1'b1;                                       // [RQ11]
            if (last_bit) begin
              next_state    = SDIP_FULL;
              next_clr_at16 = !pin_s2.force_midcode_n;
            end
          end
        end
        SDIP_FULL: begin
          // clear seen at any time in the 16th clock forces midcode
          if (!pin_s2.force_midcode_n) begin
            next_clr_at16 = 1'b1;
          end
          if (fall) begin
            next_load  = 1'b1;                                      // [RQ4] [RQ5]
            next_state = SDIP_DONE;
          end
        end
        SDIP_DONE: begin
          next_state = SDIP_DONE;                                   // [RQ12]
        end
      endcase
    end
  end

  // frame state registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state      <= SDIP_IDLE;
      latch_load <= 1'b0;
      clr_at16   <= 1'b0;
    end else begin
      state      <= next_state;
      latch_load <= next_load;
      clr_at16   <= next_clr_at16;
    end
  end

  // shift register and bit counter; the word is not cleared at frame start
  // since sixteen shifts replace every bit before it can be loaded
  always_comb begin
    next_shreg   = shreg;
    next_bit_cnt = bit_cnt;
    if (cnt_clear) begin
      next_bit_cnt = `SDIP_CNT_RESET;
    end else if (shift_now) begin
      next_shreg   = {shreg[14:0], pin_s2.data};                   // [RQ11] [RQ6]
      next_bit_cnt = bit_cnt + 5'h01;
    end
  end

  // datapath registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= `SDIP_CNT_RESET;                                   // [RQ15]
      shreg   <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
    end
  end

  // converter latch: midcode wins over the shifted word whenever clear was seen from the 16th rising edge to the load
  always_comb begin
    load_mid   = clr_at16 || !pin_s2.force_midcode_n;
    next_latch = dac_latch;
    if (next_load) begin
      next_latch = load_mid ? `SDIP_MIDCODE : shreg;               // [RQ4] [RQ5] [RQ14]
    end
  end

  // latch register; it only moves together with latch_load
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dac_latch <= `SDIP_MIDCODE;                                   // [RQ15]
    end else begin
      dac_latch <= next_latch;
    end
  end

  // overflow flag: a full fifo cannot stall the pin, so the word is counted lost;
  // the flag pulses for one cycle per lost word
  always_comb begin
    next_dropped = latch_load && !fifo_in_ready;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      word_dropped <= 1'b0;
    end else begin
      word_dropped <= next_dropped;
    end
  end

  // each loaded latch value that finds room in the fifo is also queued for a downstream consumer;
  // only words that really reached the latch enter the queue
  sdip_fifo #(
    .WIDTH (`SDIP_WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (latch_load),
    .in_ready  (fifo_in_ready),
    .in_data   (dac_latch),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );
endmodule // sdip_port

//--- sdip_consts.svh
// constants for the serial converter input port
`ifndef SDIP_CONSTS_SVH
`define SDIP_CONSTS_SVH
`define SDIP_WORD_BITS     16
`define SDIP_MIDCODE       16'h0000
`define SDIP_FULL_POS      16'h7FFF
`define SDIP_FULL_NEG      16'h8000
`define SDIP_CNT_RESET     5'h00
`define SDIP_WAIT_NS       100
`define SDIP_GAP_NS        20
`define SDIP_LEAD_NS       20
`define SDIP_CLK_NS        10
`define SDIP_WAIT_CYC      ((`SDIP_WAIT_NS + `SDIP_CLK_NS - 1) / `SDIP_CLK_NS)
`endif

//--- sdip_pkg.sv
// types for the serial converter input port
package sdip_pkg;
  typedef logic signed [15:0] sdip_word_t;
  typedef struct packed {
    logic sel_n;
    logic bit_clk;
    logic data;
    logic force_midcode_n;
  } sdip_pins_t;
  typedef enum logic [1:0] {
    SDIP_IDLE  = 2'b00,
    SDIP_SHIFT = 2'b01,
    SDIP_FULL  = 2'b10,
    SDIP_DONE  = 2'b11
  } sdip_state_t;
endpackage

//--- sdip_fifo.sv
// small fifo holding latched words for the consumer
`timescale 1ns/100ps
module sdip_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic             do_wr, do_rd, next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic [AW:0]      used;
  logic [AW+1:0]    held;

  // occupancy counts the registered head word too
  always_comb begin
    used           = wr_ptr - rd_ptr;
    held           = {1'b0, used} + (AW+2)'(out_valid);
    in_ready       = (held < (AW+2)'(DEPTH));
    do_wr          = in_valid && in_ready;
    do_rd          = (used != '0) && (!out_valid || out_ready);
    next_wr_ptr    = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    next_out_valid = do_rd ? 1'b1 : (out_ready ? 1'b0 : out_valid);
    next_out_data  = do_rd ? mem[rd_ptr[AW-1:0]] : out_data;
  end

  // storage has no reset; only pointers and head are controlled
  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end
endmodule // sdip_fifo

//--- sdip_port_assertions.sv
// concurrent checks on the converter input port
`timescale 1ns/100ps
module sdip_port_assertions #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 nrst,
  // watched ports
  input wire sdip_pkg::sdip_pins_t pins,
  input wire sdip_pkg::sdip_word_t dac_latch,
  input wire logic                 latch_load,
  input wire logic                 word_valid,
  input wire logic                 word_ready,
  input wire sdip_pkg::sdip_word_t word_data,
  input wire logic                 word_dropped
);
  import sdip_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // a frame lasts far longer than 8 cycles, so loads never come close together
  property p_pulse; latch_load |=> !latch_load [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("latch load repeated");
  property p_hold; $changed(dac_latch) |-> latch_load; endproperty
  a_hold: assert property (p_hold) else $error("latch moved without load");
  property p_idle; pins.sel_n [*8] |-> !latch_load; endproperty
  a_idle: assert property (p_idle) else $error("load while deselected");
  property p_mid; latch_load && !$past(pins.force_midcode_n, 6) |-> dac_latch == 16'h0000; endproperty
  a_mid: assert property (p_mid) else $error("clear did not give midcode");
  // the word lands in storage one edge after the load and reaches the head one edge later
  property p_push;
    latch_load && !word_valid |-> ##2 (word_valid && word_data == $past(dac_latch, 2));
  endproperty
  a_push: assert property (p_push) else $error("latched word not queued");
  property p_drop; word_dropped |-> $past(latch_load) && word_valid; endproperty
  a_drop: assert property (p_drop) else $error("drop without full buffer");
  property p_stall; word_valid && !word_ready |=> word_valid && $stable(word_data); endproperty
  a_stall: assert property (p_stall) else $error("stream head changed while stalled");
  property p_rst; $rose(nrst) |-> dac_latch == 16'h0000 && !word_valid; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule // sdip_port_assertions

//--- sdip_host.sv
// behavioural host that drives select, bit clock, data and clear
`timescale 1ns/100ps
module sdip_host (
  // pins toward the port
  output sdip_pkg::sdip_pins_t pins
);
  import sdip_pkg::*;
  // idle pins; clock stands still low between frames
  initial pins = 4'b1001;
  // one frame of n clocks; cs_n high gives a frame the port must ignore
  task automatic xfer(input logic [15:0] w, input int n, input logic cs_n, input logic clr);
    if ($realtime < 100000) #(100000 - $realtime); // power-up wait
    pins.sel_n = cs_n; // held for the whole word
    pins.force_midcode_n = clr;
    #40;               // lead before first rise
    for (int i = 0; i < n; i++) begin
      pins.data = (i < 16) ? w[15-i] : ~pins.data; // msb first
      #80 pins.bit_clk = 1'b1;
      #80 pins.bit_clk = 1'b0;
    end
    pins.data = ~pins.data; // no stale bit after the frame
    #120 pins.sel_n = 1'b1; // wait after last fall
    pins.force_midcode_n = 1'b1;
    #40;                    // deselect gap
  endtask
endmodule // sdip_host

//--- testbench.sv
// top testbench for the converter input port
`timescale 1ns/100ps
`include "sdip_consts.svh"
module testbench;
  import sdip_pkg::*;
  logic       ref_clk, nrst, word_ready, latch_load, word_valid, word_dropped;
  sdip_pins_t pins;
  sdip_word_t dac_latch, word_data;
  int         error_cnt, samples_checked, loads, drops;
  sdip_host host (.pins(pins));
  sdip_port #(.FIFO_DEPTH(16)) dut (.ref_clk(ref_clk), .nrst(nrst), .pins(pins),
    .dac_latch(dac_latch), .latch_load(latch_load), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .word_dropped(word_dropped));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // count pulses, since a load lands inside the host's frame tail
  always @(posedge ref_clk) begin
    if (latch_load) loads++;
    if (word_dropped) drops++;
  end
  task check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task frame(input logic [15:0] w, input int n, input logic cs_n, input logic clr,
             input int nl, input logic [15:0] exp);
    loads = 0;
    host.xfer(w, n, cs_n, clr);
    check(16'(loads), 16'(nl));
    check(dac_latch, exp);
  endtask
  task t_reset;
    check(dac_latch, `SDIP_MIDCODE);
    check({15'h0, word_valid}, 16'h0000);
  endtask
  task t_codes;
    frame(`SDIP_FULL_POS, 16, 0, 1, 1, `SDIP_FULL_POS);
    frame(`SDIP_FULL_NEG, 16, 0, 1, 1, `SDIP_FULL_NEG);
    frame(16'hA5C3, 16, 0, 1, 1, 16'hA5C3);
  endtask
  task t_clear;
    frame(16'h1234, 16, 0, 0, 1, `SDIP_MIDCODE);
  endtask
  task t_ghost;
    frame(16'h1234, 16, 0, 1, 1, 16'h1234);
    frame(16'h5555, 16, 1, 1, 0, 16'h1234);
  endtask
  task t_abort;
    frame(16'h0F0F, 10, 0, 1, 0, 16'h1234);
    frame(16'h0F0F, 16, 0, 1, 1, 16'h0F0F);
  endtask
  task t_extra;
    frame(16'h3C3C, 20, 0, 1, 1, 16'h3C3C);
  endtask
  // fill the buffer past its depth with the consumer stalled, then drain it
  task t_fifo;
    @(posedge ref_clk) #1 word_ready = 1'b0;
    drops = 0;
    for (int i = 0; i < 17; i++) frame(16'(i), 16, 0, 1, 1, 16'(i));
    check(16'(drops), 16'h0001);
    for (int i = 0; i < 16; i++) begin
      check(word_data, 16'(i));
      @(posedge ref_clk) #1 word_ready = 1'b1;
      @(posedge ref_clk) #1 word_ready = 1'b0;
    end
    check({15'h0, word_valid}, 16'h0000);
  endtask
  task report_and_stop;
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    word_ready = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    repeat (12) @(posedge ref_clk);
    #1 nrst = 1'b1;
    t_reset;
    t_codes;
    t_clear;
    t_ghost;
    t_abort;
    t_extra;
    t_fifo;
    report_and_stop;
  end
endmodule // testbench
bind sdip_port sdip_port_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.ref_clk(ref_clk),
  .nrst(nrst), .pins(pins), .dac_latch(dac_latch), .latch_load(latch_load),
  .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
  .word_dropped(word_dropped));
